// [hw/stcm_pkg.sv]
// Purpose: shared constants and types for the sync timer connection mux
// Assumes: 8-bit register port, word index addressing
// Notes:   offsets are register indices on the plain register port
package stcm_pkg;

	// ==========================================================
	// register map
	localparam logic [1:0] STCM_ADDR_CONN = 2'h0;
	localparam logic [1:0] STCM_ADDR_STC  = 2'h1;
	localparam logic [7:0] STCM_CONN_RST  = 8'h00;
	localparam logic [7:0] STCM_STC_RST   = 8'h00;

	// ==========================================================
	// connection control field positions
	localparam int STCM_SMOD_HI = 7;
	localparam int STCM_SMOD_LO = 6;
	localparam int STCM_CLAMP_MODE_SEL   = 5;
	localparam int STCM_VINV    = 4;
	localparam int STCM_MEAS_HI = 3;
	localparam int STCM_MEAS_LO = 2;
	localparam int STCM_HCINV   = 1;
	localparam int STCM_OUTINV  = 0;

	// ==========================================================
	// serial timer control field positions
	localparam int STCM_I2C_HI  = 7;
	localparam int STCM_I2C_LO  = 5;
	localparam int STCM_CONNOE  = 4;
	localparam int STCM_PWMEN   = 3;
	localparam int STCM_PWMSEL  = 2;
	localparam int STCM_ICK_HI  = 1;
	localparam int STCM_ICK_LO  = 0;

	// ==========================================================
	// mode encodings
	localparam logic [1:0] STCM_SYNC_NORMAL   = 2'h0;
	localparam logic [1:0] STCM_SYNC_SONG     = 2'h1;
	localparam logic [1:0] STCM_SYNC_COMPOS   = 2'h2;
	localparam logic [1:0] STCM_SYNC_SEPARATE = 2'h3;
	localparam logic [1:0] STCM_MEAS_NORMAL   = 2'h0;
	localparam logic [1:0] STCM_MEAS_VERT     = 2'h1;
	localparam logic [1:0] STCM_MEAS_HORZ     = 2'h2;
	localparam logic [1:0] STCM_MEAS_DIV      = 2'h3;

	// output pin function select
	typedef enum logic [1:0] {STCM_PIN_PORT, STCM_PIN_TIMER, STCM_PIN_CONN} stcm_pinfn_t;

	// sync pin levels from outside
	typedef struct packed {
		logic vsync;
		logic hsync;
		logic csync;
		logic spare;
	} stcm_syncin_t;

	// timer side signals into the mux
	typedef struct packed {
		logic frt_capture_pin;
		logic eight_bit_timer_one_clock_pin;
		logic eight_bit_timer_one_reset_pin;
		logic eight_bit_timer_one_out;
		logic eight_bit_timer_x_out;
		logic frt_out_b;
		logic clamp_wave_1;
		logic clamp_wave_2;
		logic pwm_decode_result;
		logic frt_outb_enable;
		logic eight_bit_timer_one_out_sel_nz;
		logic eight_bit_timer_x_out_sel_nz;
	} stcm_tmrin_t;

	// routed timer inputs
	typedef struct packed {
		logic frt_capture_input;
		logic eight_bit_timer_one_clock_input;
		logic eight_bit_timer_one_reset_input;
	} stcm_tmrout_t;

	// one output pin: level plus function select
	typedef struct packed {
		logic        level;
		stcm_pinfn_t fn;
	} stcm_pin_t;

	typedef struct packed {
		stcm_pin_t vsync_o;
		stcm_pin_t hsync_o;
		stcm_pin_t clamp_o;
	} stcm_pins_t;

	// serial and timer control fields forwarded
	typedef struct packed {
		logic [2:0] i2c_mode;
		logic       pwm_clk_enable;
		logic       pwm_clk_sel;
		logic [1:0] tmr_int_clk_sel;
	} stcm_ctlout_t;

	// route-module state
	typedef struct packed {
		stcm_tmrout_t tmr;
		stcm_pins_t   pins;
	} stcm_route_t;

	// pure invert helper
	function automatic logic stcm_inv(input logic lvl, input logic inv);
		stcm_inv = lvl ^ inv;
	endfunction

endpackage

// [hw/stcm_route.sv]
// Purpose: registered routing of sync signals to timers and pins
// Assumes: inputs already synchronised to CLK
// Notes:   one cycle of latency from input or control to output
`timescale 1ns/1ps
module stcm_route
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// control registers
	input  wire logic [7:0]            conn_ctl,
	input  wire logic [7:0]            stc_ctl,
	// sources
	input  wire stcm_pkg::stcm_syncin_t sync_in,
	input  wire stcm_pkg::stcm_tmrin_t  tmr_in,
	// results
	output stcm_pkg::stcm_route_t       route
);
	import stcm_pkg::*;

	stcm_route_t route_r;
	stcm_route_t route_nxt;
	logic [1:0]  smod;
	logic [1:0]  meas;
	logic        vin;
	logic        hin;
	logic        cin;
	logic        internal_horizontal_input;
	logic        internal_horizontal_output;
	logic        iv;
	logic        oe;

	// ==========================================================
	// combinational routing
	always_comb
	begin
		route_nxt = route_r;
		smod = conn_ctl[STCM_SMOD_HI:STCM_SMOD_LO];
		meas = conn_ctl[STCM_MEAS_HI:STCM_MEAS_LO];
		oe   = stc_ctl[STCM_CONNOE];
		vin  = stcm_inv(sync_in.vsync, conn_ctl[STCM_VINV]);
		hin  = stcm_inv(sync_in.hsync, conn_ctl[STCM_HCINV]);
		cin  = stcm_inv(sync_in.csync, conn_ctl[STCM_HCINV]);
		// sync source selection
		case (smod)
			STCM_SYNC_NORMAL:
			begin
				internal_horizontal_input = sync_in.spare;
				internal_horizontal_output = internal_horizontal_input;
				iv  = vin;
			end
			STCM_SYNC_SONG:
			begin
				internal_horizontal_input = cin;
				internal_horizontal_output = tmr_in.clamp_wave_1;
				iv  = tmr_in.pwm_decode_result;
			end
			STCM_SYNC_COMPOS:
			begin
				internal_horizontal_input = hin;
				internal_horizontal_output = tmr_in.clamp_wave_1;
				iv  = tmr_in.pwm_decode_result;
			end
			default:
			begin
				internal_horizontal_input = hin;
				internal_horizontal_output = internal_horizontal_input;
				iv  = vin;
			end
		endcase
		// measurement connection
		if (meas == STCM_MEAS_NORMAL)
		begin
			route_nxt.tmr.frt_capture_input = tmr_in.frt_capture_pin;
			route_nxt.tmr.eight_bit_timer_one_clock_input  = tmr_in.eight_bit_timer_one_clock_pin;
			route_nxt.tmr.eight_bit_timer_one_reset_input  = tmr_in.eight_bit_timer_one_reset_pin;
		end
		else
		begin
			route_nxt.tmr.eight_bit_timer_one_clock_input = internal_horizontal_input;
			route_nxt.tmr.eight_bit_timer_one_reset_input = iv;
			case (meas)
				STCM_MEAS_VERT: route_nxt.tmr.frt_capture_input = iv;
				STCM_MEAS_HORZ: route_nxt.tmr.frt_capture_input = internal_horizontal_input;
				default:        route_nxt.tmr.frt_capture_input = tmr_in.eight_bit_timer_one_out;
			endcase
		end
		// vertical sync, horizontal sync and clamp output pins
		if (oe)
		begin
			route_nxt.pins.vsync_o.fn    = STCM_PIN_CONN;
			route_nxt.pins.vsync_o.level = stcm_inv(iv, conn_ctl[STCM_OUTINV]);
			route_nxt.pins.hsync_o.fn    = STCM_PIN_CONN;
			route_nxt.pins.hsync_o.level = stcm_inv(internal_horizontal_output, conn_ctl[STCM_OUTINV]);
			route_nxt.pins.clamp_o.fn    = STCM_PIN_CONN;
			route_nxt.pins.clamp_o.level = conn_ctl[STCM_CLAMP_MODE_SEL] ? tmr_in.clamp_wave_2
				: tmr_in.clamp_wave_1;
		end
		else
		begin
			route_nxt.pins.vsync_o.fn    = tmr_in.frt_outb_enable ? STCM_PIN_TIMER
				: STCM_PIN_PORT;
			route_nxt.pins.vsync_o.level = tmr_in.frt_outb_enable & tmr_in.frt_out_b;
			route_nxt.pins.hsync_o.fn    = tmr_in.eight_bit_timer_one_out_sel_nz ? STCM_PIN_TIMER
				: STCM_PIN_PORT;
			route_nxt.pins.hsync_o.level = tmr_in.eight_bit_timer_one_out_sel_nz & tmr_in.eight_bit_timer_one_out;
			route_nxt.pins.clamp_o.fn    = tmr_in.eight_bit_timer_x_out_sel_nz ? STCM_PIN_TIMER
				: STCM_PIN_PORT;
			route_nxt.pins.clamp_o.level = tmr_in.eight_bit_timer_x_out_sel_nz & tmr_in.eight_bit_timer_x_out;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			route_r <= '0;
		else
			route_r <= route_nxt;
	end

	assign route = route_r;

endmodule

// [hw/stcm_top.sv]
// Purpose: sync timer connection mux with its two control registers
// Assumes: pins and timer levels arrive asynchronous; register port on CLK
// Notes:   every output is a flip-flop; pin functions encoded per stcm_pinfn_t
//
// What this block does
// - modes 00/11: horizontal from spare/hsync input, vertical from vsync input
// - modes 01/10: horizontal from csync/hsync; output clamp 1; vertical decode
// - measurement 00 passes capture, clock and reset pins straight through
// - measurement 01/10/11: timer clock horizontal, reset vertical, capture varies
// - vin_invert inverts vertical sync pin level
// - hcin_invert inverts horizontal and composite pins, spare never
// - sync_out_invert inverts vertical and horizontal sync outputs
// - connection control clears on reset and standby, fully read/write
// - serial timer control clears on reset, fully read/write
// - conn_out_enable hands three pins to connection outputs
// - vertical pin: port, timer out b, or vertical signal
// - horizontal pin: port, timer one out, or horizontal output
// - clamp pin: port, timer x out, or clamp wave by clamp_mode_sel
// - present timer internal clock select field to the 8-bit timers
// - forward i2c mode and pwm clock bits
// - clamp waves arrive as inputs from the timer logic
// - pwm decode result arrives as an input from the decoder
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module stcm_top
(
	// clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RSTN,
	// standby entry level
	input  wire logic                  STANDBY,
	// register port
	input  wire logic [1:0]            ADDR,
	input  wire logic [7:0]            WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic [7:0]                 RDATA,
	// sync pins
	input  wire stcm_pkg::stcm_syncin_t SYNC_IN,
	// timer side sources
	input  wire stcm_pkg::stcm_tmrin_t  TMR_IN,
	// routed timer inputs and pins
	output stcm_pkg::stcm_tmrout_t      TMR_OUT,
	output stcm_pkg::stcm_pins_t        PINS,
	// forwarded control fields
	output stcm_pkg::stcm_ctlout_t      CTL_OUT
);
	import stcm_pkg::*;

	// all top state apart from the reset synchroniser
	typedef struct packed {
		stcm_syncin_t sync_m;
		stcm_syncin_t sync_s;
		stcm_tmrin_t  tmr_m;
		stcm_tmrin_t  tmr_s;
		logic [1:0]   stby_s;
		logic [7:0]   conn;
		logic [7:0]   stc;
		logic [7:0]   rdata;
		stcm_ctlout_t ctl;
	} stcm_state_t;

	stcm_state_t st_r;
	stcm_state_t st_nxt;
	stcm_route_t route;
	logic [1:0]  rst_sync_r;
	logic        rst_n;

	// ==========================================================
	// reset release through two flops, kept apart from the state word
	// since it runs on the raw reset while the rest runs on its copy
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	assign rst_n = rst_sync_r[1];

	// ==========================================================
	// next state
	always_comb
	begin
		st_nxt          = st_r;
		// two stage input synchronisers
		st_nxt.sync_m = SYNC_IN;
		st_nxt.sync_s = st_r.sync_m;
		st_nxt.tmr_m  = TMR_IN;
		st_nxt.tmr_s  = st_r.tmr_m;
		st_nxt.stby_s = {st_r.stby_s[0], STANDBY};
		// register writes
		if (WR && ADDR == STCM_ADDR_CONN)
			st_nxt.conn = WDATA;
		if (WR && ADDR == STCM_ADDR_STC)
			st_nxt.stc = WDATA;
		if (st_r.stby_s[1])
			st_nxt.conn = STCM_CONN_RST;
		// read data, zero for unmapped or idle
		st_nxt.rdata = 8'h00;
		if (RD)
		begin
			case (ADDR)
				STCM_ADDR_CONN: st_nxt.rdata = st_r.conn;
				STCM_ADDR_STC:  st_nxt.rdata = st_r.stc;
				default:        st_nxt.rdata = 8'h00;
			endcase
		end
		// forwarded control fields
		st_nxt.ctl.i2c_mode        = st_r.stc[STCM_I2C_HI:STCM_I2C_LO];
		st_nxt.ctl.pwm_clk_enable  = st_r.stc[STCM_PWMEN];
		st_nxt.ctl.pwm_clk_sel     = st_r.stc[STCM_PWMSEL];
		st_nxt.ctl.tmr_int_clk_sel = st_r.stc[STCM_ICK_HI:STCM_ICK_LO];
	end

	// ==========================================================
	// state register on internal reset
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r.sync_m <= '0;
			st_r.sync_s <= '0;
			st_r.tmr_m  <= '0;
			st_r.tmr_s  <= '0;
			st_r.stby_s <= 2'h0;
			st_r.conn   <= STCM_CONN_RST;
			st_r.stc    <= STCM_STC_RST;
			st_r.rdata  <= 8'h00;
			st_r.ctl    <= '0;
		end
		else
		begin
			st_r.sync_m <= st_nxt.sync_m;
			st_r.sync_s <= st_nxt.sync_s;
			st_r.tmr_m  <= st_nxt.tmr_m;
			st_r.tmr_s  <= st_nxt.tmr_s;
			st_r.stby_s <= st_nxt.stby_s;
			st_r.conn   <= st_nxt.conn;
			st_r.stc    <= st_nxt.stc;
			st_r.rdata  <= st_nxt.rdata;
			st_r.ctl    <= st_nxt.ctl;
		end
	end

	// ==========================================================
	// routing datapath
	stcm_route u_route
	(
		.clk      (CLK),
		.rst_n    (rst_n),
		.conn_ctl (st_r.conn),
		.stc_ctl  (st_r.stc),
		.sync_in  (st_r.sync_s),
		.tmr_in   (st_r.tmr_s),
		.route    (route)
	);

	// outputs straight from flops
	assign RDATA   = st_r.rdata;
	assign TMR_OUT = route.tmr;
	assign PINS    = route.pins;
	assign CTL_OUT = st_r.ctl;

endmodule

// [tb/stcm_top_props.sv]
// Purpose: port checks for the sync timer connection mux
// Assumes: pin and timer inputs reach outputs three edges later
// Notes:   register side timing per the plain register port
`timescale 1ns/1ps
module stcm_top_props
(
	// watched ports
	input wire logic                   CLK,
	input wire logic                   RSTN,
	input wire logic [1:0]             ADDR,
	input wire logic [7:0]             WDATA,
	input wire logic                   WR,
	input wire logic                   RD,
	input wire logic [7:0]             RDATA,
	input wire stcm_pkg::stcm_tmrin_t  TMR_IN,
	input wire stcm_pkg::stcm_pins_t   PINS,
	input wire stcm_pkg::stcm_ctlout_t CTL_OUT
);
	import stcm_pkg::*;
	// ==========================================================
	// properties
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
	property p_unmapped; RD && ADDR[1] |=> RDATA == 8'h00; endproperty
	property p_stc_rdback;
		WR && ADDR == STCM_ADDR_STC ##1 RD && ADDR == STCM_ADDR_STC |=> RDATA == $past(WDATA, 2);
	endproperty
	property p_ctl_fwd;
		logic [7:0] d;
		(WR && ADDR == STCM_ADDR_STC, d = WDATA) |-> ##2 CTL_OUT == {d[7:5], d[3:0]};
	endproperty
	property p_oe_on;
		WR && ADDR == STCM_ADDR_STC && WDATA[STCM_CONNOE] |-> ##2 PINS.vsync_o.fn == STCM_PIN_CONN
			&& PINS.hsync_o.fn == STCM_PIN_CONN && PINS.clamp_o.fn == STCM_PIN_CONN;
	endproperty
	property p_oe_off;
		WR && ADDR == STCM_ADDR_STC && !WDATA[STCM_CONNOE] |-> ##2 PINS.clamp_o.fn != STCM_PIN_CONN;
	endproperty
	property p_vs_tmr;
		PINS.vsync_o.fn == STCM_PIN_TIMER |-> PINS.vsync_o.level == $past(TMR_IN.frt_out_b, 3);
	endproperty
	property p_hs_tmr;
		PINS.hsync_o.fn == STCM_PIN_TIMER |-> PINS.hsync_o.level == $past(TMR_IN.eight_bit_timer_one_out, 3);
	endproperty
	property p_cl_tmr;
		PINS.clamp_o.fn == STCM_PIN_TIMER |-> PINS.clamp_o.level == $past(TMR_IN.eight_bit_timer_x_out, 3);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_stc_rdback: assert property (p_stc_rdback) else $error("stc readback wrong");
	a_ctl_fwd: assert property (p_ctl_fwd) else $error("ctl fields wrong");
	a_oe_on: assert property (p_oe_on) else $error("pins not connection");
	a_oe_off: assert property (p_oe_off) else $error("clamp pin still connection");
	a_vs_tmr: assert property (p_vs_tmr) else $error("vsync timer level");
	a_hs_tmr: assert property (p_hs_tmr) else $error("hsync timer level");
	a_cl_tmr: assert property (p_cl_tmr) else $error("clamp timer level");
	// main scenarios reached
	c_conn: cover property (PINS.clamp_o.fn == STCM_PIN_CONN);
	c_tmr: cover property (PINS.hsync_o.fn == STCM_PIN_TIMER);
	c_unmapped: cover property (RD && ADDR[1]);
endmodule
bind stcm_top stcm_top_props u_props (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .TMR_IN(TMR_IN), .PINS(PINS), .CTL_OUT(CTL_OUT));

// [tb/stcm_tmr_model.sv]
// Purpose: timer side levels seen by the mux
// Assumes: levels change right after a clock edge
// Notes:   bench chooses the levels
`timescale 1ns/1ps
module stcm_tmr_model
(
	// clock and bench levels
	input wire logic        CLK,
	input wire logic [11:0] val,
	// timer side levels
	output stcm_pkg::stcm_tmrin_t TMR_IN
);
	import stcm_pkg::*;
	// timer flops update on the edge
	initial TMR_IN = '0;
	always @(posedge CLK)
		TMR_IN <= val;
endmodule

// [tb/test_sync_timer_connection_mux.sv]
// Purpose: self-checking bench for the sync timer connection mux
// Assumes: expected results come from queues
// Notes:   random config per pass, all codes covered
`timescale 1ns/1ps
module test_sync_timer_connection_mux;
	import stcm_pkg::*;
	// ==========================================================
	// signals
	logic         CLK = 1'b0;
	logic         RSTN = 1'b0;
	logic         STANDBY = 1'b0;
	logic [1:0]   ADDR = 2'h0;
	logic [7:0]   WDATA = 8'h00;
	logic         WR = 1'b0;
	logic         RD = 1'b0;
	logic [7:0]   RDATA;
	stcm_syncin_t SYNC_IN = '0;
	stcm_tmrin_t  TMR_IN;
	stcm_tmrout_t TMR_OUT;
	stcm_pins_t   PINS;
	stcm_ctlout_t CTL_OUT;
	logic [11:0]  tval = 12'h000;
	logic         rd_d = 1'b0;
	logic [18:0]  e_v;
	logic [7:0]   kv = 8'h00;
	logic [18:0]  exp_q[$];
	logic [7:0]   rd_q[$];
	int           mismatches = 0;
	int           checks = 0;
	event         smp;
	always #4 CLK = ~CLK;
	stcm_top DUT (.CLK(CLK), .RSTN(RSTN), .STANDBY(STANDBY), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .SYNC_IN(SYNC_IN), .TMR_IN(TMR_IN),
		.TMR_OUT(TMR_OUT), .PINS(PINS), .CTL_OUT(CTL_OUT));
	stcm_tmr_model PARTNER (.CLK(CLK), .val(tval), .TMR_IN(TMR_IN));
	// ==========================================================
	// helpers
	function automatic stcm_pin_t pin_f(input logic en, input logic cl, input logic sel,
		input logic tl);
		if (en)
			return '{cl, STCM_PIN_CONN};
		if (sel)
			return '{tl, STCM_PIN_TIMER};
		return '{1'b0, STCM_PIN_PORT};
	endfunction
	function automatic logic [18:0] exp_f(input logic [7:0] c, input logic [7:0] k,
		input stcm_syncin_t s, input stcm_tmrin_t t);
		logic internal_horizontal_input;
		logic internal_horizontal_output;
		logic iv;
		logic cap;
		internal_horizontal_input = (c[7:6] == STCM_SYNC_NORMAL) ? s.spare : s.hsync ^ c[STCM_HCINV];
		if (c[7:6] == STCM_SYNC_SONG)
			internal_horizontal_input = s.csync ^ c[STCM_HCINV];
		internal_horizontal_output = (c[7] ^ c[6]) ? t.clamp_wave_1 : internal_horizontal_input;
		iv = (c[7] ^ c[6]) ? t.pwm_decode_result : s.vsync ^ c[STCM_VINV];
		cap = (c[3:2] == STCM_MEAS_VERT) ? iv : (c[3:2] == STCM_MEAS_HORZ) ? internal_horizontal_input : t.eight_bit_timer_one_out;
		if (c[3:2] == STCM_MEAS_NORMAL)
			return {t.frt_capture_pin, t.eight_bit_timer_one_clock_pin, t.eight_bit_timer_one_reset_pin,
				pin_f(k[4], iv ^ c[0], t.frt_outb_enable, t.frt_out_b),
				pin_f(k[4], internal_horizontal_output ^ c[0], t.eight_bit_timer_one_out_sel_nz, t.eight_bit_timer_one_out),
				pin_f(k[4], c[5] ? t.clamp_wave_2 : t.clamp_wave_1, t.eight_bit_timer_x_out_sel_nz, t.eight_bit_timer_x_out),
				k[7:5], k[3:0]};
		return {cap, internal_horizontal_input, iv, pin_f(k[4], iv ^ c[0], t.frt_outb_enable, t.frt_out_b),
			pin_f(k[4], internal_horizontal_output ^ c[0], t.eight_bit_timer_one_out_sel_nz, t.eight_bit_timer_one_out),
			pin_f(k[4], c[5] ? t.clamp_wave_2 : t.clamp_wave_1, t.eight_bit_timer_x_out_sel_nz, t.eight_bit_timer_x_out),
			k[7:5], k[3:0]};
	endfunction
	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d, input logic [7:0] e);
		WR <= w;
		RD <= !w;
		ADDR <= a;
		WDATA <= d;
		if (!w)
			rd_q.push_back(e);
		@(posedge CLK);
	endtask
	task automatic idle(input int n);
		WR <= 1'b0;
		RD <= 1'b0;
		repeat (n) @(posedge CLK);
	endtask
	task automatic note(input logic [7:0] c);
		exp_q.push_back(exp_f(c, kv, SYNC_IN, TMR_IN));
		-> smp;
		idle(2);
	endtask
	task automatic apply(input logic [7:0] c, input logic [7:0] k);
		kv = k;
		SYNC_IN <= 4'($urandom);
		tval <= 12'($urandom);
		bus(1'b1, STCM_ADDR_CONN, c, 8'h00);
		bus(1'b0, STCM_ADDR_CONN, 8'h00, c);
		bus(1'b1, STCM_ADDR_STC, k, 8'h00);
		bus(1'b0, STCM_ADDR_STC, 8'h00, k);
		idle(5);
		note(c);
	endtask
	task automatic rst_chk(input int n);
		RSTN <= 1'b0;
		kv = 8'h00;
		idle(n);
		RSTN <= 1'b1;
		idle(8);
		bus(1'b0, STCM_ADDR_CONN, 8'h00, STCM_CONN_RST);
		bus(1'b0, STCM_ADDR_STC, 8'h00, STCM_STC_RST);
		note(8'h00);
		$display("reset test done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// monitors: read data and routed outputs
	always @(posedge CLK)
	begin
		rd_d <= RD;
		if (rd_d)
			chk({11'h000, RDATA}, {11'h000, rd_q.pop_front()});
	end
	always @(smp)
	begin
		@(negedge CLK);
		e_v = exp_q.pop_front();
		chk({16'h0000, TMR_OUT}, {16'h0000, e_v[18:16]});
		chk({16'h0000, PINS.vsync_o}, {16'h0000, e_v[15:13]});
		chk({16'h0000, PINS.hsync_o}, {16'h0000, e_v[12:10]});
		chk({16'h0000, PINS.clamp_o}, {16'h0000, e_v[9:7]});
		chk({12'h000, CTL_OUT}, {12'h000, e_v[6:0]});
	end
	// watchdog
	initial
	begin
		#400000;
		mismatches++;
		end_of_test();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(32'hd0df));
		rst_chk(6);
		bus(1'b1, 2'h3, 8'hff, 8'h00);
		bus(1'b0, 2'h2, 8'h00, 8'h00);
		bus(1'b0, STCM_ADDR_STC, 8'h00, 8'h00);
		idle(1);
		$display("unmapped test done");
		for (int i = 0; i < 32; i++)
			apply((8'($urandom) & 8'h33) | {i[1:0], 2'h0, i[3:2], 2'h0}, 8'($urandom));
		$display("mode test done");
		STANDBY <= 1'b1;
		idle(4);
		bus(1'b1, STCM_ADDR_CONN, 8'hff, 8'h00);
		bus(1'b0, STCM_ADDR_CONN, 8'h00, 8'h00);
		bus(1'b0, STCM_ADDR_STC, 8'h00, kv);
		idle(5);
		note(8'h00);
		STANDBY <= 1'b0;
		// standby stays seen for two more edges through its synchroniser
		idle(3);
		apply(8'($urandom), 8'($urandom));
		$display("standby test done");
		rst_chk(2);
		end_of_test();
	end
endmodule
